// file: vdc_defines.svh
// Register map, reset values, field positions and limits of the
// decoder control register bank. Assumes inclusion by bare name.
`ifndef VDC_DEFINES_SVH
`define VDC_DEFINES_SVH
// Register offsets
`define VDC_A_CTL 8'h0B
`define VDC_A_HUE 8'h0F
`define VDC_A_SCL 8'h10
`define VDC_A_WCU 8'h11
`define VDC_A_OFM 8'h12
`define VDC_A_VSH 8'h13
`define VDC_A_VSL 8'h14
// Reset values
`define VDC_R_HUE 8'h00
`define VDC_R_SCL 5'h00
`define VDC_R_WCU 8'hCF
`define VDC_R_OFM 8'h06
`define VDC_R_VSH 8'h60
`define VDC_R_VSL 8'h00
`define VDC_R_LUMA_DECIMATION_DISABLE 1'b1
// Field positions
`define VDC_CTL_LUMA_DECIMATION_DISABLE 5
`define VDC_SCL_PEAK 4
`define VDC_SCL_CHROMA_GAIN_AUTO_ENABLE 3
`define VDC_SCL_KILL 2
`define VDC_OFM_RANGE 7
`define VDC_OFM_BF 4
`define VDC_OFM_CODE 3
`define VDC_OFM_LEN 2
// Output limits and code words
`define VDC_Y_MIN 10'sh010
`define VDC_Y_MAX 10'sh0FD
`define VDC_Y_FULL_MIN 10'sh000
`define VDC_Y_FULL_MAX 10'sh0FF
`define VDC_C_MIN 10'sh002
`define VDC_C_MAX 10'sh0FD
`define VDC_C_ZERO 8'h80
`define VDC_CODE_W 16'hFF00
`define VDC_ZERO8 8'h00
// Coring limits
`define VDC_CORE0 8'h00
`define VDC_CORE1 8'h08
`define VDC_CORE2 8'h10
`define VDC_CORE3 8'h20
// White crush comparison levels
`define VDC_WC_3Q 8'hC0
`define VDC_WC_HALF 8'h80
`define VDC_WC_1Q 8'h40
// Chroma gain, Q2.6: one, half and double
`define VDC_G_ONE 8'h40
`define VDC_G_MIN 8'h20
`define VDC_G_MAX 8'h80
`define VDC_G_SH 6
// Horizontal ratio: 8'hFF is full size; divisors for auto filter
`define VDC_RAT_FULL 11'h100
`define VDC_DIV2 3'h2
`define VDC_DIV3 3'h3
`define VDC_DIV7 3'h7
`endif

// file: vdc_pkg.sv
// Types shared by the control register bank and its testbench.
// Assumes vdc_defines.svh holds the register map and limit constants.
package vdc_pkg;
   // Incoming decoded sample pair with timing and low-color flags
   typedef struct packed {
      logic [7:0] luma;
      logic [7:0] chroma;
      logic sync;
      logic lowcol;
   } vdc_pix_t;
   // Formatted output word, upper byte luma, lower byte chroma
   typedef struct packed {
      logic [7:0] y;
      logic [7:0] c;
   } vdc_word_t;
   // Horizontal filter choice
   typedef enum logic [1:0] {
      VDC_F_NONE = 2'b00,
      VDC_F_CIF = 2'b01,
      VDC_F_QCIF = 2'b10,
      VDC_F_ICON = 2'b11
   } vdc_filt_t;
   // Byte serializer states, one-hot
   typedef enum logic [1:0] {
      VDC_S_FIRST = 2'b01,
      VDC_S_SECOND = 2'b10
   } vdc_ser_t;
endpackage

// file: vdc_buf.sv
// Two-entry word buffer with valid/ready on both sides.
// Assumes one clock, synchronous reset and a freezing clock enable.
`timescale 1ns/1ps
module vdc_buf #(
   parameter int W = 16,
   parameter int D = 2
) (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   logic [W-1:0] mem_r [D]; // Storage, no reset needed
   logic [AW-1:0] wp_r; // Write pointer
   logic [AW-1:0] rp_r; // Read pointer
   logic [AW:0] cnt_r; // Words held
   logic push;
   logic pop;

   // Honest full and empty flags
   assign in_ready_o = (cnt_r != (AW+1)'(D));
   assign out_valid_o = (cnt_r != '0);
   assign out_data_o = mem_r[rp_r];
   assign push = ce_i && in_valid_i && in_ready_o;
   assign pop = ce_i && out_valid_o && out_ready_i;

   // Storage writes
   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem_r[wp_r] <= in_data_i;
      end
   end

   // Pointers and count, wrap at depth
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule // vdc_buf

// file: vdc_ctrl_regs.sv
// Control register bank of the video decoder, with the pixel output
// formatter that these registers steer.
// Assumes the serial bus engine presents single-cycle register
// strobes, and all inputs are synchronous to core_clk_i.
//
// What this block does
// R01 - Hue adds signed offset to subcarrier phase
// R02 - 256 steps of 0.7 degrees
// R03 - Bit 7 picks low-pass or sharpening filters
// R04 - Chroma AGC scales chroma 0.5 to 2.0
// R05 - Bit 5 enables low-color removal
// R06 - Auto code picks filter from ratio
// R07 - Codes 01..11 force CIF, QCIF, ICON
// R08 - Sharpening mode reuses field as response
// R09 - Software writes zeros to reserved bits
// R10 - Majority point picks crush comparison level
// R11 - Crush up step accumulates per field
// R12 - Range bit sets luma limits; chroma limits are fixed
// R13 - Software keeps range limited with codes
// R14 - Coring zeroes luma below limit
// R15 - Blanking frame output sends raw samples
// R16 - Code bit inserts control codes
// R17 - Width bit picks 8 or 16-bit output
// R18 - Tristate group field picks floating outputs
// R19 - Luma line average enable reaches filters
// R20 - Chroma comb enable reaches filters
// R21 - Interlace bit selects frame or field scaling
// R22 - Upper five bits of vertical scale
// R23 - Lower byte joins below upper bits
// R24 - Luma decimation disable resets to one
// R25 - Defined bits read back last write
`timescale 1ns/1ps
`include "vdc_defines.svh"
module vdc_ctrl_regs (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic [7:0] sc_phase_i,
   output logic [7:0] sc_phase_o,
   input wire logic [7:0] h_ratio_i,
   output vdc_pkg::vdc_filt_t horiz_lowpass_select_sel_o,
   output logic peak_en_o,
   output logic horiz_lowpass_select_en_o,
   input wire logic [7:0] chroma_agc_gain_i,
   input wire logic field_end_i,
   input wire logic majority_below_i,
   output logic [7:0] crush_level_o,
   output logic crush_auto_o,
   output logic [15:0] crush_accum_o,
   input wire logic blanking_capture_enable_i,
   output logic blanking_capture_o,
   input wire logic pix_valid_i,
   output logic pix_ready_o,
   input wire vdc_pkg::vdc_pix_t pix_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [15:0] pixel_data_bus_o,
   input wire logic output_tristate_bit_i,
   output logic data_oe_o,
   output logic timing_oe_o,
   output logic clock_oe_o,
   output logic caption_valid_oe_o,
   output logic luma_line_average_enable_o,
   output logic chroma_comb_o,
   output logic interlace_o,
   output logic [12:0] vscale_ratio_o
);
   import vdc_pkg::*;

   logic [7:0] hue_r; // Hue phase offset
   logic [4:0] scl_r; // Loop control bits 7:3, low bits reserved
   logic [7:0] wcu_r; // White crush up count
   logic [7:0] ofm_r; // Output format
   logic [7:0] vsh_r; // Vertical scale upper
   logic [7:0] vsl_r; // Vertical scale lower
   logic luma_decimation_disable_r; // Luma decimation disable
   logic [6:0] hit; // One-hot register select
   vdc_word_t st_w; // Formatted word into buffer
   vdc_word_t bo_w; // Word leaving buffer
   logic bo_valid;
   logic bo_ready;
   logic load;
   vdc_ser_t ser_r;
   logic out_valid_r;
   logic [7:0] gain_eff; // Chroma gain after AGC choice
   logic [7:0] core_lim; // Active coring limit
   logic [15:0] acc_r; // Crush accumulator

   // Register select; used by both the write and read paths
   function automatic logic [6:0] reg_hit(input logic [7:0] a);
      if (a == `VDC_A_HUE) begin
         reg_hit = 7'h01;
      end else if (a == `VDC_A_SCL) begin
         reg_hit = 7'h02;
      end else if (a == `VDC_A_WCU) begin
         reg_hit = 7'h04;
      end else if (a == `VDC_A_OFM) begin
         reg_hit = 7'h08;
      end else if (a == `VDC_A_VSH) begin
         reg_hit = 7'h10;
      end else if (a == `VDC_A_VSL) begin
         reg_hit = 7'h20;
      end else if (a == `VDC_A_CTL) begin
         reg_hit = 7'h40;
      end else begin
         reg_hit = 7'h00;
      end
   endfunction

   // Auto filter from ratio; products avoid a divider
   function automatic vdc_filt_t auto_filt(input logic [7:0] r);
      if ((11'(r) * 11'(`VDC_DIV2)) > `VDC_RAT_FULL) begin
         auto_filt = VDC_F_NONE;
      end else if ((11'(r) * 11'(`VDC_DIV3)) >= `VDC_RAT_FULL) begin
         auto_filt = VDC_F_CIF;
      end else if ((11'(r) * 11'(`VDC_DIV7)) >= `VDC_RAT_FULL) begin
         auto_filt = VDC_F_QCIF;
      end else begin
         auto_filt = VDC_F_ICON;
      end
   endfunction

   // Saturating clamp of a signed sample into an 8-bit range
   function automatic logic [7:0] clamp8(input logic signed [9:0] v,
         input logic signed [9:0] lo, input logic signed [9:0] hi);
      if (v < lo) begin
         clamp8 = lo[7:0];
      end else if (v > hi) begin
         clamp8 = hi[7:0];
      end else begin
         clamp8 = v[7:0];
      end
   endfunction

   assign hit = reg_hit(reg_addr_i);

   // Register writes; reserved loop bits are never stored
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         hue_r <= `VDC_R_HUE; // [R01]
         scl_r <= `VDC_R_SCL; // [R05]
         wcu_r <= `VDC_R_WCU; // [R10]
         ofm_r <= `VDC_R_OFM; // [R17]
         vsh_r <= `VDC_R_VSH; // [R20] [R21]
         vsl_r <= `VDC_R_VSL; // [R23]
         luma_decimation_disable_r <= `VDC_R_LUMA_DECIMATION_DISABLE; // [R24]
      end else if (ce_i && reg_wr_i) begin
         if (hit[0]) hue_r <= reg_wdata_i;
         if (hit[1]) scl_r <= reg_wdata_i[7:3];
         if (hit[2]) wcu_r <= reg_wdata_i;
         if (hit[3]) ofm_r <= reg_wdata_i;
         if (hit[4]) vsh_r <= reg_wdata_i; // [R22]
         if (hit[5]) vsl_r <= reg_wdata_i;
         if (hit[6]) luma_decimation_disable_r <= reg_wdata_i[`VDC_CTL_LUMA_DECIMATION_DISABLE];
      end
   end

   // Read data, unmapped offsets and reserved bits read zero
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         reg_rdata_o <= `VDC_ZERO8;
      end else if (ce_i && reg_rd_i) begin
         if (hit[0]) begin
            reg_rdata_o <= hue_r; // [R25]
         end else if (hit[1]) begin
            reg_rdata_o <= {scl_r, 3'b000}; // [R09] [R25]
         end else if (hit[2]) begin
            reg_rdata_o <= wcu_r;
         end else if (hit[3]) begin
            reg_rdata_o <= ofm_r;
         end else if (hit[4]) begin
            reg_rdata_o <= vsh_r;
         end else if (hit[5]) begin
            reg_rdata_o <= vsl_r;
         end else if (hit[6]) begin
            reg_rdata_o <= {2'b00, luma_decimation_disable_r, 5'h00};
         end else begin
            reg_rdata_o <= `VDC_ZERO8;
         end
      end
   end

   // Hue: two's complement add, wraps like a phase; 0x80 is -90 deg
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         sc_phase_o <= `VDC_ZERO8;
      end else if (ce_i) begin
         sc_phase_o <= sc_phase_i + hue_r; // [R01] [R02]
      end
   end

   // Filter choice; sharpening reuses the field as a response code
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         horiz_lowpass_select_sel_o <= VDC_F_NONE;
         peak_en_o <= 1'b0;
         horiz_lowpass_select_en_o <= 1'b0;
      end else if (ce_i) begin
         peak_en_o <= scl_r[`VDC_SCL_PEAK]; // [R03]
         horiz_lowpass_select_en_o <= !luma_decimation_disable_r; // [R03] [R24]
         if (scl_r[`VDC_SCL_PEAK]) begin
            horiz_lowpass_select_sel_o <= vdc_filt_t'(scl_r[1:0]); // [R08]
         end else if (scl_r[1:0] == 2'b00) begin
            horiz_lowpass_select_sel_o <= auto_filt(h_ratio_i); // [R06]
         end else begin
            horiz_lowpass_select_sel_o <= vdc_filt_t'(scl_r[1:0]); // [R07]
         end
      end
   end

   // Crush comparison level every cycle; accumulator steps at a field end with majority below
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         crush_level_o <= `VDC_ZERO8;
         crush_auto_o <= 1'b0;
         acc_r <= '0;
      end else if (ce_i) begin
         crush_auto_o <= (wcu_r[7:6] == 2'b11); // [R10]
         case (wcu_r[7:6])
            2'b00: crush_level_o <= `VDC_WC_3Q;
            2'b01: crush_level_o <= `VDC_WC_HALF;
            2'b10: crush_level_o <= `VDC_WC_1Q;
            default: crush_level_o <= `VDC_ZERO8;
         endcase
         if (field_end_i && majority_below_i) begin
            acc_r <= acc_r + 16'(wcu_r[5:0]); // [R11]
         end
      end
   end
   assign crush_accum_o = acc_r;

   // Static control outputs and blanking capture override
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         blanking_capture_o <= 1'b0;
         luma_line_average_enable_o <= 1'b0;
         chroma_comb_o <= 1'b0;
         interlace_o <= 1'b0;
         vscale_ratio_o <= '0;
      end else if (ce_i) begin
         blanking_capture_o <= ofm_r[`VDC_OFM_BF] ||
            blanking_capture_enable_i; // [R15]
         luma_line_average_enable_o <= vsh_r[7]; // [R19]
         chroma_comb_o <= vsh_r[6]; // [R20]
         interlace_o <= vsh_r[5]; // [R21]
         vscale_ratio_o <= {vsh_r[4:0], vsl_r}; // [R22] [R23]
      end
   end

   // Tristate groups float only while the float request is high
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         data_oe_o <= 1'b0;
         timing_oe_o <= 1'b0;
         clock_oe_o <= 1'b0;
      end else if (ce_i) begin
         data_oe_o <= !output_tristate_bit_i; // [R18]
         timing_oe_o <= !(output_tristate_bit_i &&
            !ofm_r[0]); // [R18]
         clock_oe_o <= !(output_tristate_bit_i &&
            ofm_r[1]); // [R18]
      end
   end
   // Caption valid has no float group
   assign caption_valid_oe_o = 1'b1; // [R18]

   // Chroma gain: unity unless AGC on, then bounded to 0.5..2.0
   always_comb begin
      if (!scl_r[`VDC_SCL_CHROMA_GAIN_AUTO_ENABLE]) begin
         gain_eff = `VDC_G_ONE; // [R04]
      end else if (chroma_agc_gain_i < `VDC_G_MIN) begin
         gain_eff = `VDC_G_MIN;
      end else if (chroma_agc_gain_i > `VDC_G_MAX) begin
         gain_eff = `VDC_G_MAX;
      end else begin
         gain_eff = chroma_agc_gain_i; // [R04]
      end
   end

   // Coring limit from the two-bit field
   always_comb begin
      case (ofm_r[6:5])
         2'b01: core_lim = `VDC_CORE1;
         2'b10: core_lim = `VDC_CORE2;
         2'b11: core_lim = `VDC_CORE3;
         default: core_lim = `VDC_CORE0; // [R14]
      endcase
   end

   // Sample formatting ahead of the buffer
   always_comb begin
      logic signed [8:0] c_off;
      logic signed [17:0] c_prod;
      logic signed [9:0] c_v;
      logic signed [9:0] y_v;
      c_off = $signed({1'b0, pix_i.chroma}) -
         $signed({1'b0, `VDC_C_ZERO});
      c_prod = 18'(c_off) * 18'($signed({1'b0, gain_eff}));
      c_v = 10'(c_prod >>> `VDC_G_SH) +
         $signed({2'b00, `VDC_C_ZERO});
      y_v = $signed({2'b00, pix_i.luma});
      if (pix_i.luma < core_lim) begin
         y_v = '0; // [R14]
      end
      if (ofm_r[`VDC_OFM_RANGE]) begin
         st_w.y = clamp8(y_v, `VDC_Y_FULL_MIN,
            `VDC_Y_FULL_MAX); // [R12]
      end else begin
         st_w.y = clamp8(y_v, `VDC_Y_MIN, `VDC_Y_MAX); // [R12]
      end
      st_w.c = clamp8(c_v, `VDC_C_MIN, `VDC_C_MAX); // [R12]
      if (scl_r[`VDC_SCL_KILL] && pix_i.lowcol) begin
         st_w.c = `VDC_C_ZERO; // [R05]
      end
      if (ofm_r[`VDC_OFM_BF]) begin
         st_w = {pix_i.luma, pix_i.chroma}; // [R15]
      end else if (pix_i.sync && ofm_r[`VDC_OFM_CODE]) begin
         st_w = `VDC_CODE_W; // [R16]
      end
   end

   // Buffer so an output stall loses no word
   vdc_buf #(.W(16), .D(2)) u_buf (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .in_valid_i(pix_valid_i),
      .in_ready_o(pix_ready_o),
      .in_data_i(st_w),
      .out_valid_o(bo_valid),
      .out_ready_i(bo_ready),
      .out_data_o(bo_w)
   );

   // Output register loads when empty or being taken
   assign load = !out_valid_r || out_ready_i;
   // 8-bit mode pops as the chroma byte loads into the output register
   assign bo_ready = load && (ofm_r[`VDC_OFM_LEN] ||
      ser_r == VDC_S_SECOND); // [R17]
   assign out_valid_o = out_valid_r;

   // Output word and byte serializer
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         out_valid_r <= 1'b0;
         pixel_data_bus_o <= '0;
         ser_r <= VDC_S_FIRST;
      end else if (ce_i && load) begin
         out_valid_r <= bo_valid;
         if (bo_valid) begin
            case (ser_r)
               VDC_S_FIRST: begin
                  if (ofm_r[`VDC_OFM_LEN]) begin
                     pixel_data_bus_o <= bo_w; // [R17]
                  end else begin
                     pixel_data_bus_o <= {bo_w.y, `VDC_ZERO8};
                     ser_r <= VDC_S_SECOND; // [R17]
                  end
               end
               VDC_S_SECOND: begin
                  pixel_data_bus_o <= {bo_w.c, `VDC_ZERO8};
                  ser_r <= VDC_S_FIRST;
               end
               default: ser_r <= VDC_S_FIRST;
            endcase
         end
      end
   end

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (srst_i);

   sequence s_byte_luma;
      ce_i && load && bo_valid && !ofm_r[`VDC_OFM_LEN] &&
         ser_r == VDC_S_FIRST;
   endsequence
   sequence s_byte_chroma;
      ser_r == VDC_S_SECOND && pixel_data_bus_o[7:0] == `VDC_ZERO8;
   endsequence

   // Release edge: reset flops still load, so sampled reset gates these
   a_hue_add: assert property (!srst_i && ce_i |=> // [R01]
      sc_phase_o == 8'($past(sc_phase_i) + $past(hue_r)))
      else $error("hue phase sum wrong");
   a_auto_filter: assert property (ce_i && !scl_r[4] && // [R06]
      scl_r[1:0] == 2'b00 && h_ratio_i == 8'hFF |=>
      horiz_lowpass_select_sel_o == VDC_F_NONE)
      else $error("auto filter not none at full size");
   a_agc_unity: assert property (!scl_r[3] |-> // [R04]
      gain_eff == `VDC_G_ONE)
      else $error("chroma gain not unity with agc off");
   a_crush_accum: assert property (ce_i && field_end_i && // [R11]
      majority_below_i |=> acc_r == 16'($past(acc_r) +
      16'($past(wcu_r[5:0]))))
      else $error("crush accumulator step wrong");
   a_luma_range: assert property (!ofm_r[7] && !ofm_r[4] && // [R12]
      !(pix_i.sync && ofm_r[3]) |-> st_w.y >= 8'h10 &&
      st_w.y <= 8'hFD)
      else $error("luma outside limited range");
   a_code_insert: assert property (ofm_r[3] && !ofm_r[4] && // [R16]
      pix_i.sync |-> st_w == `VDC_CODE_W)
      else $error("control code not inserted");
   a_float_group: assert property (ce_i && // [R18]
      output_tristate_bit_i && ofm_r[1:0] == 2'b01 |=>
      !data_oe_o && timing_oe_o && clock_oe_o)
      else $error("data-only float group wrong");
   a_byte_pair: assert property (s_byte_luma |=> // [R17]
      s_byte_chroma)
      else $error("8-bit mode did not move to chroma byte");
   a_vscale_join: assert property (!srst_i && ce_i |=> // [R23]
      vscale_ratio_o == {$past(vsh_r[4:0]), $past(vsl_r)})
      else $error("vertical scale ratio not joined");
   a_hue_write: assert property (ce_i && reg_wr_i && // [R25]
      reg_addr_i == `VDC_A_HUE |=> hue_r == $past(reg_wdata_i))
      else $error("hue write not stored");
endmodule // vdc_ctrl_regs

// file: vdc_sink.sv
// Model of the logic that takes formatted words off the pixel port.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module vdc_sink (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic out_valid_i,
   input wire logic [15:0] data_i,
   output logic out_ready_o
);
   logic [1:0] ph_r; // Stall pattern phase
   logic [15:0] q[$]; // Words taken, emptied by the bench
   // Stall two cycles in four, so the buffer has to hold words
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         ph_r <= 2'h0;
      end else begin
         ph_r <= ph_r + 2'h1;
      end
   end
   assign out_ready_o = ph_r[1];
   // A word counts only at an edge where both sides agree
   always @(posedge core_clk_i) begin
      if (!srst_i && out_valid_i && out_ready_o) begin
         q.push_back(data_i);
      end
   end
endmodule // vdc_sink

// file: vdc_ctrl_regs_tb.sv
// Self-checking bench for the control register bank and formatter.
// Assumes the design files and vdc_sink.sv are compiled first.
`timescale 1ns/1ps
module vdc_ctrl_regs_tb;
   import vdc_pkg::*;
   logic core_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic ce_i = 1'b1; // Clock enable, dropped once to test the freeze
   logic [7:0] reg_addr_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_rdata_o;
   logic [7:0] sc_phase_i = 8'h10;
   logic [7:0] sc_phase_o;
   logic [7:0] h_ratio_i = 8'hFF;
   vdc_filt_t horiz_lowpass_select_sel_o;
   logic peak_en_o, horiz_lowpass_select_en_o;
   logic [7:0] chroma_agc_gain_i = 8'h80; // Gain ignored while off
   logic field_end_i = 1'b0;
   logic majority_below_i = 1'b0;
   logic [7:0] crush_level_o;
   logic crush_auto_o;
   logic [15:0] crush_accum_o;
   logic blanking_capture_enable_i = 1'b0;
   logic blanking_capture_o;
   logic pix_valid_i = 1'b0;
   logic pix_ready_o;
   vdc_pix_t pix_i = '0;
   logic out_valid_o, out_ready_i;
   logic [15:0] pixel_data_bus_o;
   logic output_tristate_bit_i = 1'b0;
   logic data_oe_o, timing_oe_o, clock_oe_o, caption_valid_oe_o;
   logic luma_line_average_enable_o, chroma_comb_o, interlace_o;
   logic [12:0] vscale_ratio_o;
   logic [7:0] ra [7] = '{8'h0B, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14};
   logic [7:0] rv [7] = '{8'h20, 8'h00, 8'h00, 8'hCF, 8'h06, 8'h60, 8'h00};
   logic [7:0] wv [7] = '{8'h00, 8'h80, 8'hA8, 8'h3F, 8'h06, 8'h7A, 8'h00};
   logic [7:0] hr [4] = '{8'hFF, 8'h60, 8'h40, 8'h20};
   logic [7:0] lm [4] = '{8'h00, 8'h08, 8'h10, 8'h20};
   int n_fail = 0;
   int cmp_count = 0;
   vdc_ctrl_regs vdc_ctrl_regs_i (.*);
   vdc_sink vdc_sink_i (.core_clk_i(core_clk_i), .srst_i(srst_i),
      .out_valid_i(out_valid_o), .data_i(pixel_data_bus_o),
      .out_ready_o(out_ready_i));
   // 100 MHz clock
   always #5 core_clk_i = ~core_clk_i;
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Case equality, so an unknown never matches
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Settle just after an edge, clear of that edge's updates
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   // Read data lands at the edge that takes the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      #1;
      chk(reg_rdata_o, e);
   endtask
   // Hold the sample until an edge finds the buffer ready
   task automatic px(input logic [7:0] y, c, input logic s, l);
      @(posedge core_clk_i);
      pix_valid_i <= 1'b1;
      pix_i <= '{y, c, s, l};
      #1;
      while (pix_ready_o !== 1'b1) @(posedge core_clk_i) #1;
      @(posedge core_clk_i);
      pix_valid_i <= 1'b0;
   endtask
   // Bounded wait for n words at the sink
   task automatic wq(input int n);
      int k;
      k = 0;
      while (vdc_sink_i.q.size() < n && k < 60) begin
         wt(1);
         k++;
      end
      chk(vdc_sink_i.q.size(), n);
   endtask
   // Set the format, send one sample, compare one or two beats
   task automatic pc(input logic [7:0] f, y, c, input logic s, l,
      input logic [15:0] e0, e1);
      int n;
      n = f[2] ? 1 : 2;
      wr(8'h12, f);
      wt(2);
      px(y, c, s, l);
      wq(n);
      chk(vdc_sink_i.q[0], e0);
      if (n == 2) chk(vdc_sink_i.q[1], e1);
      vdc_sink_i.q.delete();
   endtask
   // Pulse the field marker with a majority verdict
   task automatic fe(input logic b);
      @(posedge core_clk_i);
      field_end_i <= 1'b1;
      majority_below_i <= b;
      @(posedge core_clk_i);
      field_end_i <= 1'b0;
   endtask
   // Watchdog: the run needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge core_clk_i);
      n_fail++;
      test_done;
   end
   initial begin
      repeat (3) @(posedge core_clk_i);
      srst_i <= 1'b0;
      wt(2);
      for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
      chk({luma_line_average_enable_o, chroma_comb_o, interlace_o,
         horiz_lowpass_select_en_o, crush_auto_o, caption_valid_oe_o}, 6'h1B);
      $display("test reset done");
      // Reserved bits written as zero, as software must
      for (int i = 0; i < 7; i++) wr(ra[i], wv[i]);
      wr(8'h20, 8'h5A);
      for (int i = 0; i < 7; i++) rd(ra[i], wv[i]);
      rd(8'h20, 8'h00);
      wt(2);
      chk(sc_phase_o, 8'h90);
      chk({horiz_lowpass_select_en_o, peak_en_o, horiz_lowpass_select_sel_o}, 4'hD);
      chk(vscale_ratio_o, 13'h1A00);
      chk({chroma_comb_o, interlace_o}, 2'h3);
      wr(8'h13, 8'h80);
      wt(2);
      chk({luma_line_average_enable_o, chroma_comb_o, interlace_o}, 3'h4);
      // Clock enable low: a write strobe must not land
      @(posedge core_clk_i) ce_i <= 1'b0;
      wr(8'h0F, 8'h55);
      @(posedge core_clk_i) ce_i <= 1'b1;
      rd(8'h0F, 8'h80);
      $display("test registers done");
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk_i) h_ratio_i <= hr[i];
         wr(8'h10, 8'h00);
         wt(2);
         chk(horiz_lowpass_select_sel_o, i);
         wr(8'h10, {3'h0, i[1:0], 3'h0});
         wt(2);
         chk(horiz_lowpass_select_sel_o, i);
      end
      $display("test filter done");
      for (int i = 0; i < 4; i++) begin
         wr(8'h11, {i[1:0], 6'h05});
         wt(2);
         chk(crush_level_o, 16'(8'h40 * (3 - i)));
         chk(crush_auto_o, i == 3);
      end
      fe(1'b1);
      fe(1'b0);
      fe(1'b1);
      wr(8'h11, 8'hFF);
      wt(2);
      fe(1'b1);
      wt(2);
      chk(crush_accum_o, 16'h0049);
      $display("test crush done");
      wr(8'h10, 8'h20);
      pc(8'h06, 8'h05, 8'h01, 0, 0, 16'h1002, 0);
      pc(8'h06, 8'hFF, 8'hFF, 0, 0, 16'hFDFD, 0);
      pc(8'h86, 8'h05, 8'h01, 0, 0, 16'h0502, 0);
      pc(8'h06, 8'h90, 8'h33, 0, 1, 16'h9080, 0);
      pc(8'h06, 8'h50, 8'h60, 1, 0, 16'h5060, 0);
      pc(8'h0E, 8'h50, 8'h60, 1, 0, 16'hFF00, 0);
      pc(8'h16, 8'h05, 8'h01, 0, 0, 16'h0501, 0);
      chk(blanking_capture_o, 1'b1);
      pc(8'h02, 8'h50, 8'h60, 0, 0, 16'h5000, 16'h6000);
      for (int i = 0; i < 4; i++) begin
         pc({1'b1, i[1:0], 5'h06}, lm[i] - 8'h01, 8'h40, 0, 0,
            {i == 0 ? 8'hFF : 8'h00, 8'h40}, 0);
         pc({1'b1, i[1:0], 5'h06}, lm[i], 8'h40, 0, 0, {lm[i], 8'h40}, 0);
      end
      // Chroma gain on: 2.0 doubles, a quarter is held at one half
      wr(8'h10, 8'h60);
      pc(8'h06, 8'h50, 8'h90, 0, 0, 16'h50A0, 0);
      @(posedge core_clk_i) chroma_agc_gain_i <= 8'h10;
      pc(8'h06, 8'h50, 8'h90, 0, 0, 16'h5088, 0);
      wr(8'h12, 8'h06);
      for (int i = 0; i < 6; i++) px(8'h20 + 8'(i), 8'h80, 1'b0, 1'b0);
      wq(6);
      for (int i = 0; i < 6; i++) chk(vdc_sink_i.q[i], {8'h20 + 8'(i), 8'h80});
      $display("test pixel done");
      @(posedge core_clk_i) output_tristate_bit_i <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wr(8'h12, {6'h01, i[1:0]});
         wt(2);
         chk({data_oe_o, timing_oe_o, clock_oe_o, caption_valid_oe_o},
            {1'b0, i[0], i < 2, 1'b1});
      end
      @(posedge core_clk_i) output_tristate_bit_i <= 1'b0;
      wt(3);
      chk({data_oe_o, timing_oe_o, clock_oe_o}, 3'h7);
      $display("test tristate done");
      test_done;
   end
endmodule // vdc_ctrl_regs_tb
